// ### core/uncore_event_select.sv
// Event selection and increment generation for the home logic and memory controller.
`timescale 1ns/1ps
module uncore_event_select
    import uncore_event_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Event selection
    input wire logic [7:0] event_code,
    input wire logic [7:0] unit_mask,
    // Home tracker read occupancy, io-hub / remote / local
    input wire logic [NUM_UNITS-1:0][OCC_W-1:0] home_tracker_read_occupancy,
    // Conflict tracking table updates
    input wire logic join_valid,
    input wire logic [CT_IDX_W-1:0] join_idx,
    input wire logic [1:0] join_src,
    input wire logic release_valid,
    input wire logic [CT_IDX_W-1:0] release_idx,
    // Bypass requests to the memory controller
    input wire logic bypass_valid,
    input wire logic bypass_is_local,
    input wire logic bypass_is_read,
    // Memory controller channel status
    input wire logic [NUM_UNITS-1:0] normal_full_read,
    input wire logic [NUM_UNITS-1:0] normal_full_write,
    input wire logic [NUM_UNITS-1:0] isoch_full_read,
    input wire logic [NUM_UNITS-1:0] isoch_full_write,
    input wire logic [NUM_UNITS-1:0] pending_read,
    input wire logic [NUM_UNITS-1:0] pending_write,
    input wire logic [NUM_UNITS-1:0][OCC_W-1:0] normal_read_occupancy,
    input wire logic [NUM_UNITS-1:0][OCC_W-1:0] isoch_read_occupancy,
    // Results
    output logic [INC_W-1:0] increment,
    output logic bypass_taken,
    output logic bypass_refused,
    output logic join_refused
);

    typedef struct packed {
        logic [INC_W-1:0] increment;
        logic bypass_taken;
        logic bypass_refused;
        logic join_refused;
    } state_t;

    state_t st;
    state_t next_st;

    logic ct_join_refused;
    logic ct_release_strobe;
    logic [1:0] ct_release_peak;
    logic [NUM_UNITS-1:0] tracker_conflict_cycles;

    // ==========================================================
    // Conflict tracking table
    conflict_tracking_table u_conflict_tracking_table (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .join_valid(join_valid),
        .join_idx(join_idx),
        .join_src(join_src),
        .release_valid(release_valid),
        .release_idx(release_idx),
        .join_refused(ct_join_refused),
        .release_strobe(ct_release_strobe),
        .release_peak(ct_release_peak),
        .conflict_active(tracker_conflict_cycles)
    );

    // ==========================================================
    // Per-unit selection terms
    logic [NUM_UNITS-1:0] rd_sel;
    logic [NUM_UNITS-1:0] wr_sel;
    logic [NUM_UNITS-1:0] isoch_sel;
    logic [NUM_UNITS-1:0][INC_W-1:0] home_occ_term;
    logic [NUM_UNITS-1:0][INC_W-1:0] normal_occ_term;
    logic [NUM_UNITS-1:0][INC_W-1:0] isoch_occ_term;
    logic [NUM_UNITS-1:0] conflict_term;
    logic [NUM_UNITS-1:0] normal_full_term;
    logic [NUM_UNITS-1:0] isoch_full_term;
    logic [NUM_UNITS-1:0] pending_term;

    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        // Only exact single-bit masks are listed, plus UM_ALL for isochronous occupancy; other combined masks select nothing.
        assign rd_sel[u] = unit_mask == (UM_RD0 << u);
        assign wr_sel[u] = unit_mask == (UM_WR0 << u);
        assign isoch_sel[u] = rd_sel[u] || unit_mask == UM_ALL;
        assign home_occ_term[u] = rd_sel[u]
            ? INC_W'(home_tracker_read_occupancy[u]) : INC_RESET;
        assign normal_occ_term[u] = rd_sel[u]
            ? INC_W'(normal_read_occupancy[u]) : INC_RESET;
        assign isoch_occ_term[u] = isoch_sel[u]
            ? INC_W'(isoch_read_occupancy[u]) : INC_RESET;
        assign conflict_term[u] = rd_sel[u] && tracker_conflict_cycles[u];
        assign normal_full_term[u] = (rd_sel[u] && normal_full_read[u])
            || (wr_sel[u] && normal_full_write[u]);
        assign isoch_full_term[u] = (rd_sel[u] && isoch_full_read[u])
            || (wr_sel[u] && isoch_full_write[u]);
        assign pending_term[u] = (rd_sel[u] && pending_read[u])
            || (wr_sel[u] && pending_write[u]);
    end

    // ==========================================================
    // Bypass legality
    // A remote write that claims the bypass path is reported, never counted.
    logic bypass_legal;
    assign bypass_legal = bypass_is_local || bypass_is_read;

    // ==========================================================
    // Increment selection
    // Every source is sampled once per uncore clock, so the counter sees one
    // increment per cycle and a full-width sum never wraps.
    always_comb begin
        next_st = st;
        next_st.increment = INC_RESET;
        next_st.bypass_taken = bypass_valid && bypass_legal;
        next_st.bypass_refused = bypass_valid && !bypass_legal;
        next_st.join_refused = ct_join_refused;
        case (event_code)
            EV_HOME_OCC: begin
                next_st.increment = home_occ_term[0] + home_occ_term[1]
                    + home_occ_term[2];
            end
            EV_CONFLICT_PEAK: begin
                if (ct_release_strobe && ((unit_mask == UM_PEAK2 && ct_release_peak == CT_PEAK_2)
                    || (unit_mask == UM_PEAK3 && ct_release_peak == CT_PEAK_3))) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_CONFLICT_CYC: begin
                if (|conflict_term) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_BYPASS: begin
                if (unit_mask == UM_RD0 && bypass_valid && bypass_legal) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_NORM_FULL: begin
                if (|normal_full_term) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_ISOC_FULL: begin
                if (|isoch_full_term) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_PENDING: begin
                if (|pending_term) begin
                    next_st.increment = INC_ONE;
                end
            end
            EV_NORM_OCC: begin
                next_st.increment = normal_occ_term[0] + normal_occ_term[1]
                    + normal_occ_term[2];
            end
            EV_ISOC_OCC: begin
                next_st.increment = isoch_occ_term[0] + isoch_occ_term[1]
                    + isoch_occ_term[2];
            end
            default: begin
                next_st.increment = INC_RESET;
            end
        endcase
    end

    // ==========================================================
    // State register
    // The block runs only on the uncore clock, so every cycle event is in its periods.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign increment = st.increment;
    assign bypass_taken = st.bypass_taken;
    assign bypass_refused = st.bypass_refused;
    assign join_refused = st.join_refused;

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_HOME_OCC: assert property (
        event_code == EV_HOME_OCC && unit_mask == UM_RD0
        |=> increment == INC_W'($past(home_tracker_read_occupancy[0])))
        else $error("Io-hub tracker occupancy not added.");

    AST_PEAK3_AT_RELEASE: assert property (
        event_code == EV_CONFLICT_PEAK && unit_mask == UM_PEAK3
        && ct_release_strobe && ct_release_peak == CT_PEAK_3
        |=> increment == INC_ONE)
        else $error("Three-way conflict release not counted.");

    AST_PEAK_ONLY_AT_RELEASE: assert property (
        event_code == EV_CONFLICT_PEAK && !ct_release_strobe |=> increment == INC_RESET)
        else $error("Conflict peak counted while entry still live.");

    AST_CONFLICT_CYC: assert property (
        event_code == EV_CONFLICT_CYC && unit_mask == UM_PEAK3
        |=> increment == INC_W'($past(tracker_conflict_cycles[2])))
        else $error("Local tracker conflict cycle mismatch.");

    sequence s_bad_bypass;
        event_code == EV_BYPASS && unit_mask == UM_RD0 && bypass_valid
        && !bypass_is_local && !bypass_is_read;
    endsequence

    sequence s_bypass_dropped;
        ##1 increment == INC_RESET && bypass_refused && !bypass_taken;
    endsequence

    AST_BYPASS_LEGAL: assert property (s_bad_bypass |-> s_bypass_dropped)
        else $error("Remote write counted as bypass.");

    AST_BYPASS_COUNT: assert property (
        event_code == EV_BYPASS && unit_mask == UM_RD0 && bypass_valid && bypass_is_local
        |=> increment == INC_ONE && bypass_taken)
        else $error("Local bypass not counted.");

    AST_NORM_FULL_WR: assert property (
        event_code == EV_NORM_FULL && unit_mask == UM_WR0
        |=> increment == INC_W'($past(normal_full_write[0])))
        else $error("Channel 0 write queue full cycle mismatch.");

    AST_ISOC_FULL_RD: assert property (
        event_code == EV_ISOC_FULL && unit_mask == UM_RD0
        |=> increment == INC_W'($past(isoch_full_read[0])))
        else $error("Channel 0 isochronous full cycle mismatch.");

    AST_PENDING_RD: assert property (
        event_code == EV_PENDING && unit_mask == UM_PEAK2
        |=> increment == INC_W'($past(pending_read[1])))
        else $error("Channel 1 pending read cycle mismatch.");

    AST_NORM_OCC: assert property (
        event_code == EV_NORM_OCC && unit_mask == UM_PEAK3
        |=> increment == INC_W'($past(normal_read_occupancy[2])))
        else $error("Channel 2 normal occupancy not added.");

    AST_ISOC_ALL: assert property (
        event_code == EV_ISOC_OCC && unit_mask == UM_ALL
        |=> increment == INC_W'($past(isoch_read_occupancy[0]))
        + INC_W'($past(isoch_read_occupancy[1])) + INC_W'($past(isoch_read_occupancy[2])))
        else $error("All-channel isochronous occupancy wrong.");

    AST_UNLISTED: assert property (
        event_code < EV_HOME_OCC || event_code > EV_ISOC_OCC |=> increment == INC_RESET)
        else $error("Unlisted event code produced an increment.");

    AST_COMBINED_MASK: assert property (
        event_code == EV_NORM_FULL && unit_mask == (UM_RD0 | UM_PEAK2)
        |=> increment == INC_RESET)
        else $error("Combined unit mask produced an increment.");

    AST_HOME_OCC_REMOTE: assert property (
        event_code == EV_HOME_OCC && unit_mask == UM_PEAK2
        |=> increment == INC_W'($past(home_tracker_read_occupancy[1])))
        else $error("Remote tracker occupancy not added.");

    AST_PEAK2_AT_RELEASE: assert property (
        event_code == EV_CONFLICT_PEAK && unit_mask == UM_PEAK2
        && ct_release_strobe && ct_release_peak == CT_PEAK_2
        |=> increment == INC_ONE)
        else $error("Two-way conflict release not counted.");

    // A release whose peak does not match the mask must stay silent.
    AST_PEAK_MISMATCH: assert property (
        event_code == EV_CONFLICT_PEAK && unit_mask == UM_PEAK2
        && ct_release_strobe && ct_release_peak == CT_PEAK_3
        |=> increment == INC_RESET)
        else $error("Three-way release counted under the two-way mask.");

    AST_CONFLICT_REMOTE: assert property (
        event_code == EV_CONFLICT_CYC && unit_mask == UM_PEAK2
        |=> increment == INC_W'($past(tracker_conflict_cycles[1])))
        else $error("Remote tracker conflict cycle mismatch.");

    AST_JOIN_REFUSED: assert property (
        ct_join_refused |=> join_refused)
        else $error("Refused join not reported.");

    AST_REMOTE_READ_BYPASS: assert property (
        event_code == EV_BYPASS && unit_mask == UM_RD0 && bypass_valid
        && !bypass_is_local && bypass_is_read
        |=> increment == INC_ONE && bypass_taken && !bypass_refused)
        else $error("Remote read bypass not counted.");

    AST_NORM_FULL_RD2: assert property (
        event_code == EV_NORM_FULL && unit_mask == UM_PEAK3
        |=> increment == INC_W'($past(normal_full_read[2])))
        else $error("Channel 2 read queue full cycle mismatch.");

    AST_ISOC_FULL_WR1: assert property (
        event_code == EV_ISOC_FULL && unit_mask == (UM_WR0 << 1)
        |=> increment == INC_W'($past(isoch_full_write[1])))
        else $error("Channel 1 isochronous write full cycle mismatch.");

    AST_PENDING_WR2: assert property (
        event_code == EV_PENDING && unit_mask == (UM_WR0 << 2)
        |=> increment == INC_W'($past(pending_write[2])))
        else $error("Channel 2 pending write cycle mismatch.");

    AST_ISOC_OCC_CH1: assert property (
        event_code == EV_ISOC_OCC && unit_mask == UM_PEAK2
        |=> increment == INC_W'($past(isoch_read_occupancy[1])))
        else $error("Channel 1 isochronous occupancy not added.");

endmodule

// ### core/uncore_event_pkg.sv
// Shared constants for the uncore home and memory-controller event selection logic.
package uncore_event_pkg;

    // ==========================================================
    // Event codes
    localparam logic [7:0] EV_HOME_OCC = 8'h23;
    localparam logic [7:0] EV_CONFLICT_PEAK = 8'h24;
    localparam logic [7:0] EV_CONFLICT_CYC = 8'h25;
    localparam logic [7:0] EV_BYPASS = 8'h26;
    localparam logic [7:0] EV_NORM_FULL = 8'h27;
    localparam logic [7:0] EV_ISOC_FULL = 8'h28;
    localparam logic [7:0] EV_PENDING = 8'h29;
    localparam logic [7:0] EV_NORM_OCC = 8'h2a;
    localparam logic [7:0] EV_ISOC_OCC = 8'h2b;

    // ==========================================================
    // Unit masks: read or source select for units 0..2, write select, all channels
    localparam logic [7:0] UM_RD0 = 8'h01;
    localparam logic [7:0] UM_WR0 = 8'h08;
    localparam logic [7:0] UM_ALL = 8'h07;
    localparam logic [7:0] UM_PEAK2 = 8'h02;
    localparam logic [7:0] UM_PEAK3 = 8'h04;

    // ==========================================================
    // Widths, depths and reset values
    localparam int NUM_UNITS = 3;
    localparam int OCC_W = 6;
    localparam int INC_W = 8;
    localparam int CT_ENTRIES = 8;
    localparam int CT_IDX_W = 3;
    localparam logic [INC_W-1:0] INC_RESET = 8'h00;
    localparam logic [INC_W-1:0] INC_ONE = 8'h01;

    // ==========================================================
    // Conflict tracking table
    localparam logic [1:0] CT_MAX_GROUP = 2'h3;
    localparam logic [1:0] CT_PEAK_2 = 2'h2;
    localparam logic [1:0] CT_PEAK_3 = 2'h3;
    localparam logic [1:0] CT_FIRST = 2'h1;
    localparam logic [1:0] SRC_IO_HUB = 2'h0;
    localparam logic [1:0] SRC_REMOTE = 2'h1;
    localparam logic [1:0] SRC_LOCAL = 2'h2;

endpackage

// ### core/conflict_tracking_table.sv
// Conflict tracking table: groups of conflicting tracker requests and their peak sizes.
`timescale 1ns/1ps
module conflict_tracking_table
    import uncore_event_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // Request joining a conflict group
    input wire logic join_valid,
    input wire logic [CT_IDX_W-1:0] join_idx,
    input wire logic [1:0] join_src,
    // Group release
    input wire logic release_valid,
    input wire logic [CT_IDX_W-1:0] release_idx,
    // Results
    output logic join_refused,
    output logic release_strobe,
    output logic [1:0] release_peak,
    output logic [NUM_UNITS-1:0] conflict_active
);

    typedef struct packed {
        logic valid;
        logic [1:0] src;
        logic [1:0] count;
    } entry_t;

    typedef struct packed {
        entry_t [CT_ENTRIES-1:0] ent;
    } table_t;

    table_t st;
    table_t next_st;

    // ==========================================================
    // Next state
    // Members never leave a group early, so the live count is also the peak.
    always_comb begin
        next_st = st;
        join_refused = 1'b0;
        release_strobe = 1'b0;
        release_peak = 2'h0;
        if (release_valid && st.ent[release_idx].valid) begin
            release_strobe = 1'b1;
            release_peak = st.ent[release_idx].count;
            next_st.ent[release_idx] = '0;
        end
        if (join_valid) begin
            if (release_valid && release_idx == join_idx) begin
                join_refused = 1'b1;
            end else if (!st.ent[join_idx].valid) begin
                next_st.ent[join_idx] = '{valid: 1'b1, src: join_src, count: CT_FIRST};
            end else if (st.ent[join_idx].count == CT_MAX_GROUP) begin
                join_refused = 1'b1;
            end else begin
                next_st.ent[join_idx].count = st.ent[join_idx].count + 2'h1;
            end
        end
    end

    // ==========================================================
    // Per-tracker conflict presence
    for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
        logic [CT_ENTRIES-1:0] hit;
        for (genvar e = 0; e < CT_ENTRIES; e++) begin : g_ent
            assign hit[e] = st.ent[e].valid && st.ent[e].src == 2'(u)
                && st.ent[e].count >= CT_PEAK_2;
        end
        assign conflict_active[u] = |hit;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    AST_GROUP_LIMIT: assert property (
        join_valid && !release_valid && st.ent[join_idx].valid
        && st.ent[join_idx].count == CT_MAX_GROUP
        |-> join_refused ##1 st.ent[$past(join_idx)].count == CT_MAX_GROUP)
        else $error("Conflict group grew beyond three requests.");

endmodule

// ### dv/queue_status_model.sv
// Behavioural model of the tracker and memory-controller status seen by the event logic.
`timescale 1ns/1ps
module queue_status_model
    import uncore_event_pkg::*;
(
    // Scenario control from the bench
    input wire logic [2:0] kind,
    input wire logic [2:0] chan,
    input wire logic [OCC_W-1:0] occ,
    // Status toward the event logic
    output logic [NUM_UNITS-1:0][OCC_W-1:0] home_occ,
    output logic [NUM_UNITS-1:0][OCC_W-1:0] norm_occ,
    output logic [NUM_UNITS-1:0][OCC_W-1:0] isoch_occ,
    output logic [5:0][NUM_UNITS-1:0] flags
);
    // ==========================================================
    // Status generation
    // Each source gets its own offset so a wrong unit or channel pick shows as a wrong sum.
    // Only one flag group is active at a time, so a wrong read/write pick reads as zero.
    always_comb begin
        for (int i = 0; i < NUM_UNITS; i++) begin
            home_occ[i] = occ + OCC_W'(i);
            norm_occ[i] = occ + OCC_W'(4 + i);
            isoch_occ[i] = occ + OCC_W'(8 + i);
        end
        for (int k = 0; k < 6; k++) begin
            flags[k] = (kind == 3'(k)) ? chan : 3'h0;
        end
    end
endmodule

// ### dv/uncore_home_memctl_event_select_bench.sv
// Self-checking testbench for the uncore event selection block.
`timescale 1ns/1ps
module uncore_home_memctl_event_select_bench;
    import uncore_event_pkg::*;

    // ==========================================================
    // Signals
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] event_code = 8'h00;
    logic [7:0] unit_mask = 8'h00;
    logic join_valid = 1'b0;
    logic [2:0] join_idx = 3'h0;
    logic [1:0] join_src = 2'h0;
    logic release_valid = 1'b0;
    logic [2:0] release_idx = 3'h0;
    logic bypass_valid = 1'b0;
    logic bypass_is_local = 1'b0;
    logic bypass_is_read = 1'b0;
    logic [2:0] kind = 3'h7;
    logic [2:0] chan = 3'h0;
    logic [OCC_W-1:0] occ = 6'h00;
    logic [NUM_UNITS-1:0][OCC_W-1:0] home_occ;
    logic [NUM_UNITS-1:0][OCC_W-1:0] norm_occ;
    logic [NUM_UNITS-1:0][OCC_W-1:0] isoch_occ;
    logic [5:0][NUM_UNITS-1:0] flags;
    logic [7:0] increment;
    logic bypass_taken;
    logic bypass_refused;
    logic join_refused;
    int err_total = 0;
    int n_tests = 0;

    // ==========================================================
    // Instances
    queue_status_model far_side (.kind(kind), .chan(chan), .occ(occ), .home_occ(home_occ),
        .norm_occ(norm_occ), .isoch_occ(isoch_occ), .flags(flags));

    uncore_event_select DUT (.ref_clk(ref_clk), .nrst(nrst), .event_code(event_code),
        .unit_mask(unit_mask), .home_tracker_read_occupancy(home_occ),
        .join_valid(join_valid), .join_idx(join_idx), .join_src(join_src),
        .release_valid(release_valid), .release_idx(release_idx),
        .bypass_valid(bypass_valid), .bypass_is_local(bypass_is_local),
        .bypass_is_read(bypass_is_read), .normal_full_read(flags[0]),
        .normal_full_write(flags[1]), .isoch_full_read(flags[2]),
        .isoch_full_write(flags[3]), .pending_read(flags[4]), .pending_write(flags[5]),
        .normal_read_occupancy(norm_occ), .isoch_read_occupancy(isoch_occ),
        .increment(increment), .bypass_taken(bypass_taken),
        .bypass_refused(bypass_refused), .join_refused(join_refused));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Shared tasks
    // Inputs always move 1 ns after an edge, so the registered answer is read settled there.
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask

    task automatic sel(input logic [7:0] code, input logic [7:0] mask);
        event_code = code;
        unit_mask = mask;
    endtask

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Leaves join_valid high so back-to-back joins never assign it twice in one step.
    task automatic join_req(input logic [2:0] idx, input logic [1:0] src, input logic refused);
        join_valid = 1'b1;
        join_idx = idx;
        join_src = src;
        step();
        chk("join refused", {7'h0, join_refused}, {7'h0, refused});
    endtask

    task automatic rel(input logic [2:0] idx);
        release_valid = 1'b1;
        release_idx = idx;
        step();
        release_valid = 1'b0;
        chk("release count", increment, INC_ONE);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_occ();
        logic [7:0] codes [3];
        codes = '{EV_HOME_OCC, EV_NORM_OCC, EV_ISOC_OCC};
        occ = 6'h05;
        for (int c = 0; c < 3; c++) begin
            for (int u = 0; u < 3; u++) begin
                sel(codes[c], 8'h01 << u);
                step();
                chk("occupancy", increment, 8'(5 + 4 * c + u));
            end
        end
        sel(EV_ISOC_OCC, UM_ALL);
        step();
        chk("isoch all", increment, 8'h2a);
        $display("occupancy test done");
    endtask

    task automatic t_flags();
        logic [7:0] codes [3];
        codes = '{EV_NORM_FULL, EV_ISOC_FULL, EV_PENDING};
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 6; m++) begin
                sel(codes[c], 8'h01 << m);
                kind = 3'(2 * c + m / 3);
                chan = 3'h1 << (m % 3);
                step();
                chk("flag hit", increment, INC_ONE);
                step();
                chk("flag held", increment, INC_ONE);
                chan = ~chan;
                step();
                chk("flag other channel", increment, INC_RESET);
                kind = 3'(2 * c + 1 - m / 3);
                chan = 3'h7;
                step();
                chk("flag other kind", increment, INC_RESET);
            end
        end
        $display("flag test done");
    endtask

    task automatic t_unlisted();
        logic [7:0] codes [3];
        logic [7:0] masks [3];
        codes = '{EV_NORM_FULL, 8'h22, EV_NORM_OCC};
        masks = '{8'h03, UM_RD0, UM_ALL};
        kind = 3'h0;
        chan = 3'h7;
        for (int i = 0; i < 3; i++) begin
            sel(codes[i], masks[i]);
            step();
            chk("unlisted pair", increment, INC_RESET);
        end
        $display("unlisted test done");
    endtask

    task automatic t_bypass();
        sel(EV_BYPASS, UM_RD0);
        for (int b = 0; b < 4; b++) begin
            bypass_is_local = b[1];
            bypass_is_read = b[0];
            bypass_valid = 1'b1;
            step();
            bypass_valid = 1'b0;
            chk("bypass count", increment, (b == 0) ? INC_RESET : INC_ONE);
            chk("bypass taken", {7'h0, bypass_taken}, {7'h0, b != 0});
            chk("bypass refused", {7'h0, bypass_refused}, {7'h0, b == 0});
            step();
            chk("bypass idle", increment, INC_RESET);
        end
        $display("bypass test done");
    endtask

    task automatic t_conflict();
        sel(EV_CONFLICT_CYC, 8'h04);
        join_req(3'h0, SRC_LOCAL, 1'b0);
        join_req(3'h0, SRC_LOCAL, 1'b0);
        join_valid = 1'b0;
        chk("one member", increment, INC_RESET);
        step();
        chk("two members", increment, INC_ONE);
        join_req(3'h0, SRC_LOCAL, 1'b0);
        join_req(3'h0, SRC_LOCAL, 1'b1);
        join_valid = 1'b0;
        sel(EV_CONFLICT_PEAK, UM_PEAK3);
        step();
        chk("entry live", increment, INC_RESET);
        rel(3'h0);
        step();
        chk("release once", increment, INC_RESET);
        sel(EV_CONFLICT_CYC, UM_RD0);
        join_req(3'h1, SRC_IO_HUB, 1'b0);
        join_req(3'h1, SRC_IO_HUB, 1'b0);
        join_valid = 1'b0;
        step();
        chk("io hub conflict", increment, INC_ONE);
        // The io-hub group is still live, so a wrong tracker pick would show here.
        sel(EV_CONFLICT_CYC, 8'h02);
        step();
        chk("remote idle", increment, INC_RESET);
        join_req(3'h2, SRC_REMOTE, 1'b0);
        join_req(3'h2, SRC_REMOTE, 1'b0);
        join_valid = 1'b0;
        step();
        chk("remote conflict", increment, INC_ONE);
        sel(EV_CONFLICT_PEAK, UM_PEAK2);
        rel(3'h1);
        $display("conflict test done");
    endtask

    // ==========================================================
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        chk("reset value", increment, INC_RESET);
        chk("reset flags", {5'h00, bypass_taken, bypass_refused, join_refused}, 8'h00);
        nrst = 1'b1;
        t_occ();
        t_flags();
        t_unlisted();
        t_bypass();
        t_conflict();
        close_out();
    end

    // The scenarios need about 125 cycles; sixteen times that means a hang.
    initial begin
        repeat (2000) @(posedge ref_clk);
        err_total++;
        close_out();
    end
endmodule
